// File: hw/cip_pkg.sv
package cip_pkg;

	// ==========================================================
	// line geometry
	localparam int ADDR_W     = 32;
	localparam int LINE_BYTES = 32;
	localparam int LINE_W     = LINE_BYTES * 8;
	localparam int OFFSET_W   = 5;
	localparam int INDEX_W    = 4;
	localparam int DEPTH      = 16;
	localparam int INDEX_LSB  = OFFSET_W;
	localparam int TAG_LSB    = OFFSET_W + INDEX_W;
	localparam int TAG_W      = ADDR_W - TAG_LSB;
	localparam int STORE_W    = TAG_W + LINE_W;

	// ==========================================================
	// coherence line states
	typedef enum logic [1:0] {
		MESI_INVALID   = 2'b00,
		MESI_SHARED    = 2'b01,
		MESI_EXCLUSIVE = 2'b10,
		MESI_MODIFIED  = 2'b11
	} mesi_t;

	localparam mesi_t RESET_LINE_STATE = MESI_INVALID;

	// ==========================================================
	// intervention commands
	typedef enum logic [3:0] {
		CMD_SHARED_READ     = 4'h0, // shared_line_read_request
		CMD_OWNERSHIP_READ  = 4'h1, // ownership_read_request
		CMD_UPGRADE         = 4'h2, // shared_to_exclusive_request
		CMD_INVALIDATE      = 4'h3,
		CMD_COPY_BACK       = 4'h4,
		CMD_COPY_BACK_INV   = 4'h5,
		CMD_WRITE_INVALIDATE = 4'h6,
		CMD_READ_DISCARD    = 4'h7
	} icmd_t;

	// ==========================================================
	// fsm of the intervention engine
	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_LOOKUP = 2'b01,
		ST_UPDATE = 2'b10,
		ST_RESP   = 2'b11
	} eng_state_t;

endpackage

// File: hw/line_store.sv
`timescale 1ns/100ps
// ==========================================================
// tag and data store, one line per entry, registered read
module line_store
	import cip_pkg::*;
(
	input  wire logic               ref_clk_i,
	input  wire logic               wr_en_i,
	input  wire logic [INDEX_W-1:0] wr_index_i,
	input  wire logic [STORE_W-1:0] wr_data_i,
	input  wire logic [INDEX_W-1:0] rd_index_i,
	output logic      [STORE_W-1:0] rd_data_o
);

	logic [STORE_W-1:0] mem [DEPTH];

	// read-first: a same-cycle write is seen on the next read only
	always_ff @(posedge ref_clk_i) begin
		if (wr_en_i) begin
			mem[wr_index_i] <= wr_data_i;
		end
		rd_data_o <= mem[rd_index_i];
	end

endmodule

// File: hw/coherent_intervention_port.sv
`timescale 1ns/100ps
module coherent_intervention_port
	import cip_pkg::*;
(
	input  wire logic              ref_clk_i,
	input  wire logic              rst_i,
	// intervention requests; the port exists only because this agent caches
	input  wire logic              req_valid_i,
	output logic                   req_ready_o,
	input  wire logic [3:0]        req_cmd_i,
	input  wire logic [ADDR_W-1:0] req_addr_i,
	input  wire logic              req_self_i,
	// intervention responses
	output logic                   resp_valid_o,
	input  wire logic              resp_ready_i,
	output logic [1:0]             resp_state_o,
	output logic                   resp_has_data_o,
	output logic [LINE_W-1:0]      resp_data_o,
	output logic                   resp_self_o,
	// line installs from the local cache pipeline
	input  wire logic              fill_valid_i,
	output logic                   fill_ready_o,
	input  wire logic [ADDR_W-1:0] fill_addr_i,
	input  wire logic [1:0]        fill_state_i,
	input  wire logic [LINE_W-1:0] fill_data_i,
	// one-cycle pulse when our own request is seen in global order
	output logic                   self_order_o
);

	// ==========================================================
	// helpers
	function automatic logic [INDEX_W-1:0] index_of(input logic [ADDR_W-1:0] a);
		index_of = a[TAG_LSB-1:INDEX_LSB];
	endfunction

	function automatic logic [TAG_W-1:0] tag_of(input logic [ADDR_W-1:0] a);
		tag_of = a[ADDR_W-1:TAG_LSB];
	endfunction

	// data goes back only for reads of owned lines and for dirty copy-backs or write-invalidates
	function automatic logic wants_data(input icmd_t c, input mesi_t s);
		logic hit_clean_or_dirty;
		hit_clean_or_dirty = (s == MESI_MODIFIED) || (s == MESI_EXCLUSIVE);
		case (c)
			CMD_SHARED_READ,
			CMD_OWNERSHIP_READ,
			CMD_READ_DISCARD:     wants_data = hit_clean_or_dirty;
			CMD_COPY_BACK,
			CMD_COPY_BACK_INV,
			CMD_WRITE_INVALIDATE: wants_data = (s == MESI_MODIFIED);
			default:              wants_data = 1'b0;
		endcase
	endfunction

	// state after a foreign intervention; invalid lines stay invalid
	function automatic mesi_t after_snoop(input icmd_t c, input mesi_t s);
		case (c)
			CMD_SHARED_READ:  after_snoop = (s == MESI_INVALID) ? s : MESI_SHARED;
			CMD_OWNERSHIP_READ,
			CMD_UPGRADE:      after_snoop = MESI_INVALID;
			CMD_INVALIDATE,
			CMD_COPY_BACK_INV,
			CMD_WRITE_INVALIDATE: after_snoop = MESI_INVALID;
			CMD_COPY_BACK:    after_snoop = (s == MESI_MODIFIED) ? MESI_EXCLUSIVE : s;
			CMD_READ_DISCARD: after_snoop = s;
			default:          after_snoop = s;
		endcase
	endfunction

	// ==========================================================
	// state
	eng_state_t         st;
	eng_state_t         next_st;
	mesi_t              line_st [DEPTH];
	mesi_t              next_line_st [DEPTH];
	icmd_t              cmd;
	icmd_t              next_cmd;
	logic [ADDR_W-1:0]  addr;
	logic [ADDR_W-1:0]  next_addr;
	logic               self_req;
	logic               next_self_req;
	mesi_t              prev;
	mesi_t              next_prev;
	logic [1:0]         resp_state;
	logic [1:0]         next_resp_state;
	logic               resp_has_data;
	logic               next_resp_has_data;
	logic [LINE_W-1:0]  resp_data;
	logic [LINE_W-1:0]  next_resp_data;
	logic               resp_self;
	logic               next_resp_self;
	logic               self_order;
	logic               next_self_order;

	logic               accept;
	logic               fill_take;
	logic               st_wr_en;
	logic [INDEX_W-1:0] st_wr_index;
	logic [STORE_W-1:0] st_wr_data;
	logic [INDEX_W-1:0] st_rd_index;
	logic [STORE_W-1:0] st_rd_data;
	logic               hit;
	mesi_t              looked_up;

	// one request in flight at a time keeps answers in arrival order
	assign req_ready_o  = (st == ST_IDLE);
	assign accept       = req_valid_i && req_ready_o;
	// interventions win the store; a fill waits for a quiet idle cycle
	assign fill_ready_o = (st == ST_IDLE) && !req_valid_i;
	assign fill_take    = fill_valid_i && fill_ready_o;
	assign resp_valid_o = (st == ST_RESP);

	assign resp_state_o    = resp_state;
	assign resp_has_data_o = resp_has_data;
	assign resp_data_o     = resp_data;
	assign resp_self_o     = resp_self;
	assign self_order_o    = self_order;

	// lookup result is valid in ST_LOOKUP
	assign hit       = (st_rd_data[STORE_W-1:LINE_W] == tag_of(addr))
	                   && (line_st[index_of(addr)] != MESI_INVALID);
	assign looked_up = hit ? line_st[index_of(addr)] : MESI_INVALID;

	// ==========================================================
	// store ports
	always_comb begin
		st_rd_index = index_of(req_addr_i);
		st_wr_en    = 1'b0;
		st_wr_index = index_of(fill_addr_i);
		st_wr_data  = {tag_of(fill_addr_i), fill_data_i};
		if (fill_take) begin
			st_wr_en = 1'b1;
		end
	end

	line_store u_store (
		.ref_clk_i  (ref_clk_i),
		.wr_en_i    (st_wr_en),
		.wr_index_i (st_wr_index),
		.wr_data_i  (st_wr_data),
		.rd_index_i (st_rd_index),
		.rd_data_o  (st_rd_data)
	);

	// ==========================================================
	// engine next state
	always_comb begin
		next_st            = st;
		next_line_st       = line_st;
		next_cmd           = cmd;
		next_addr          = addr;
		next_self_req      = self_req;
		next_prev          = prev;
		next_resp_state    = resp_state;
		next_resp_has_data = resp_has_data;
		next_resp_data     = resp_data;
		next_resp_self     = resp_self;
		next_self_order    = 1'b0;
		if (fill_take) begin
			next_line_st[index_of(fill_addr_i)] = mesi_t'(fill_state_i);
		end
		case (st)
			ST_IDLE: begin
				if (accept) begin
					next_cmd      = icmd_t'(req_cmd_i);
					next_addr     = req_addr_i;
					next_self_req = req_self_i;
					next_st       = ST_LOOKUP;
				end
			end
			ST_LOOKUP: begin
				next_prev          = looked_up;
				next_resp_state    = looked_up;
				next_resp_self     = self_req;
				// whole line, single beat, tag bits dropped
				next_resp_data     = st_rd_data[LINE_W-1:0];
				next_resp_has_data = self_req ? 1'b0 : wants_data(cmd, looked_up);
				next_st            = ST_UPDATE;
			end
			ST_UPDATE: begin
				// own copy is left to the local pipeline, only the order is flagged
				if (self_req) begin
					next_self_order = 1'b1;
				end else if (prev != MESI_INVALID) begin
					// a miss leaves the slot alone, it may hold a line of another tag
					next_line_st[index_of(addr)] = after_snoop(cmd, prev);
				end
				next_st = ST_RESP;
			end
			ST_RESP: begin
				if (resp_ready_i) begin
					next_st = ST_IDLE;
				end
			end
			default: begin
				next_st = ST_IDLE;
			end
		endcase
	end

	// ==========================================================
	// engine registers
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			st            <= ST_IDLE;
			line_st       <= '{default: RESET_LINE_STATE};
			cmd           <= CMD_SHARED_READ;
			addr          <= '0;
			self_req      <= 1'b0;
			prev          <= MESI_INVALID;
			resp_state    <= 2'h0;
			resp_has_data <= 1'b0;
			resp_data     <= '0;
			resp_self     <= 1'b0;
			self_order    <= 1'b0;
		end else begin
			st            <= next_st;
			line_st       <= next_line_st;
			cmd           <= next_cmd;
			addr          <= next_addr;
			self_req      <= next_self_req;
			prev          <= next_prev;
			resp_state    <= next_resp_state;
			resp_has_data <= next_resp_has_data;
			resp_data     <= next_resp_data;
			resp_self     <= next_resp_self;
			self_order    <= next_self_order;
		end
	end

endmodule

// File: tb/cip_checker.sv
`timescale 1ns/100ps
// ====
// port protocol watch
module cip_checker
	import cip_pkg::*;
(
	input wire logic       ref_clk_i,
	input wire logic       rst_i,
	input wire logic       req_valid_i,
	input wire logic       req_ready_o,
	input wire logic       resp_valid_o,
	input wire logic       resp_ready_i,
	input wire logic [1:0] resp_state_o,
	input wire logic       resp_has_data_o,
	input wire logic       resp_self_o,
	input wire logic       fill_ready_o,
	input wire logic       self_order_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	// take, then two quiet cycles, then the answer
	sequence taken_s; req_valid_i && req_ready_o; endsequence
	sequence answer_s; !resp_valid_o [*2] ##1 resp_valid_o; endsequence
	resp_timing_a: assert property (taken_s |=> answer_s)
		else $error("answer not three cycles after take");
	busy_refuse_a: assert property (taken_s |=> !req_ready_o [*3])
		else $error("second request accepted while busy");
	answer_hold_a: assert property (resp_valid_o && !resp_ready_i |=> resp_valid_o
		&& $stable(resp_state_o) && $stable(resp_has_data_o))
		else $error("answer changed before accept");
	release_idle_a: assert property (resp_valid_o && resp_ready_i |=>
		req_ready_o && !resp_valid_o)
		else $error("no idle after accept");
	self_dry_a: assert property (resp_valid_o && resp_self_o |->
		!resp_has_data_o)
		else $error("self answer carried data");
	data_owner_a: assert property (resp_valid_o && resp_has_data_o |->
		resp_state_o[1])
		else $error("data from a line not owned");
	self_mark_a: assert property ($rose(resp_valid_o) |->
		self_order_o == resp_self_o)
		else $error("order pulse wrong");
	pulse_once_a: assert property (self_order_o |=> !self_order_o)
		else $error("order pulse too long");
	fill_gate_a: assert property (fill_ready_o |-> req_ready_o && !req_valid_i)
		else $error("install taken during intervention");
endmodule
bind coherent_intervention_port cip_checker i_cip_checker (.ref_clk_i, .rst_i, .req_valid_i,
	.req_ready_o, .resp_valid_o, .resp_ready_i, .resp_state_o, .resp_has_data_o, .resp_self_o,
	.fill_ready_o, .self_order_o);

// File: tb/mgr_model.sv
`timescale 1ns/100ps
// ====
// manager stand-in; exists only for a cached agent
module mgr_model
	import cip_pkg::*;
(
	input  wire logic              ref_clk_i,
	input  wire logic              req_ready_i,
	input  wire logic              resp_valid_i,
	input  wire logic [LINE_W+3:0] resp_i,
	output logic                   req_valid_o,
	output logic [3:0]             req_cmd_o,
	output logic [ADDR_W-1:0]      req_addr_o,
	output logic                   req_self_o,
	output logic                   resp_ready_o
);
	initial begin
		req_valid_o = 1'b0;
		req_cmd_o = 4'hF;
		req_addr_o = 32'h0;
		req_self_o = 1'b0;
		resp_ready_o = 1'b0;
	end
	// every request goes out, own ones too, dataless ok
	task automatic send(input logic [3:0] c, input logic [ADDR_W-1:0] a, input logic s,
		input int stall, output logic [LINE_W+3:0] r, output int tmo);
		int n;
		req_valid_o = 1'b1;
		req_cmd_o = c;
		req_addr_o = a;
		req_self_o = s;
		n = 0;
		do begin
			@(posedge ref_clk_i);
			n++;
		end while (!req_ready_i && n < 50);
		#2;
		// released lines carry junk so a stale value is never trusted
		req_valid_o = 1'b0;
		req_cmd_o = ~c;
		req_addr_o = ~a;
		req_self_o = ~s;
		repeat (stall) @(posedge ref_clk_i);
		if (stall > 0) #2;
		resp_ready_o = 1'b1;
		do begin
			@(posedge ref_clk_i);
			n++;
		end while (!resp_valid_i && n < 100);
		r = resp_i;
		tmo = (n >= 100);
		#2;
		resp_ready_o = 1'b0;
	endtask
endmodule

// File: tb/test_coherent_intervention_port.sv
`timescale 1ns/100ps
// ====
// random interventions and installs against a line table
module test_coherent_intervention_port
	import cip_pkg::*;
;
	logic              ref_clk_i, rst_i, req_valid_i, req_ready_o, req_self_i, resp_valid_o;
	logic              resp_ready_i, resp_has_data_o, resp_self_o, fill_valid_i, fill_ready_o;
	logic              self_order_o;
	logic [1:0]        resp_state_o, fill_state_i;
	logic [3:0]        req_cmd_i;
	logic [ADDR_W-1:0] req_addr_i, fill_addr_i, a;
	logic [LINE_W-1:0] resp_data_o, fill_data_i;
	logic [LINE_W+3:0] got;
	logic [31:0]       rnd;
	int                fail_count, cmp_count, tmo;
	logic [TAG_W-1:0]  m_tag [DEPTH];
	logic [1:0]        m_st [DEPTH];
	logic [LINE_W-1:0] m_dat [DEPTH];

	coherent_intervention_port i_coherent_intervention_port (.ref_clk_i, .rst_i, .req_valid_i,
		.req_ready_o, .req_cmd_i, .req_addr_i, .req_self_i, .resp_valid_o, .resp_ready_i,
		.resp_state_o, .resp_has_data_o, .resp_data_o, .resp_self_o, .fill_valid_i,
		.fill_ready_o, .fill_addr_i, .fill_state_i, .fill_data_i, .self_order_o);
	mgr_model i_mgr_model (.ref_clk_i, .req_ready_i(req_ready_o), .resp_valid_i(resp_valid_o),
		.resp_i({resp_self_o, resp_has_data_o, resp_state_o, resp_data_o}),
		.req_valid_o(req_valid_i), .req_cmd_o(req_cmd_i), .req_addr_o(req_addr_i),
		.req_self_o(req_self_i), .resp_ready_o(resp_ready_i));

	initial begin
		ref_clk_i = 1'b0;
		forever #12.5 ref_clk_i = ~ref_clk_i;
	end
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		return x ^ (x << 5);
	endfunction
	task automatic check(input logic [LINE_W+3:0] seen, input logic [LINE_W+3:0] want);
		cmp_count++;
		if (seen !== want) begin
			fail_count++;
			$display("[FAIL] %0t answer %h want %h", $time, seen[LINE_W+3:LINE_W],
				want[LINE_W+3:LINE_W]);
		end
	endtask
	task automatic close_out();
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// lines come up empty after reset
	task automatic do_reset();
		rst_i = 1'b1;
		repeat (6) @(posedge ref_clk_i);
		#2;
		rst_i = 1'b0;
		for (int k = 0; k < DEPTH; k++) m_st[k] = 2'h0;
	endtask
	task automatic fill(input logic [1:0] s, input logic [LINE_W-1:0] d);
		int n;
		fill_valid_i = 1'b1;
		fill_addr_i = a;
		fill_state_i = s;
		fill_data_i = d;
		n = 0;
		do begin
			@(posedge ref_clk_i);
			n++;
		end while (!fill_ready_o && n < 20);
		fail_count += (n >= 20);
		#2;
		fill_valid_i = 1'b0;
		fill_data_i = ~d;
		m_tag[a[TAG_LSB-1:INDEX_LSB]] = a[ADDR_W-1:TAG_LSB];
		m_st[a[TAG_LSB-1:INDEX_LSB]] = s;
		m_dat[a[TAG_LSB-1:INDEX_LSB]] = d;
		// let an edge pass with valid low so a following install is a new transfer
		@(posedge ref_clk_i);
		#2;
	endtask
	// expected answer from the table, then the state change
	task automatic probe(input logic [3:0] c, input logic s, input int stall);
		logic [INDEX_W-1:0] ix;
		logic [1:0]         prv;
		logic               hd;
		logic [LINE_W+3:0]  want;
		ix = a[TAG_LSB-1:INDEX_LSB];
		prv = (m_st[ix] != 2'h0 && m_tag[ix] == a[ADDR_W-1:TAG_LSB]) ? m_st[ix] : 2'h0;
		hd = !s && ((c inside {0, 1, 7} && prv[1]) || (c inside {4, 5, 6} && prv == 2'h3));
		i_mgr_model.send(c, a, s, stall, got, tmo);
		fail_count += tmo;
		if (!hd) got[LINE_W-1:0] = '0;
		want = {s, hd, prv, hd ? m_dat[ix] : {LINE_W{1'b0}}};
		check(got, want);
		if (!s && prv != 2'h0) begin
			case (c)
			4'h0: m_st[ix] = 2'h1;
			4'h1, 4'h2, 4'h3, 4'h5, 4'h6: m_st[ix] = 2'h0;
			4'h4: if (prv == 2'h3) m_st[ix] = 2'h2;
			default: ;
			endcase
		end
	endtask

	// back-to-back ops, every command code, one reset in mid-run
	initial begin
		fail_count = 0;
		cmp_count = 0;
		rnd = 32'h5F;
		fill_valid_i = 1'b0;
		fill_addr_i = 32'h0;
		fill_state_i = 2'h0;
		fill_data_i = '0;
		do_reset();
		for (int i = 0; i < 400; i++) begin
			rnd = xs(rnd);
			a = {22'h0, rnd[4], rnd[3:0], rnd[9:5]};
			if (i == 200) do_reset();
			if (rnd[12:10] < 3) fill(rnd[14:13], {4{rnd, xs(rnd)}});
			else probe(4'(i), rnd[15] & rnd[16], int'(rnd[18:17]));
		end
		close_out();
	end
	// far beyond 400 ops of at most five cycles each
	initial begin
		#1000000;
		fail_count++;
		close_out();
	end
endmodule
